// File: logic/trp_ctrl.sv
/*
 User-side controller of the reconfiguration port, ordered by software through four registers.
 It assumes a plain register port whose read data is wanted one cycle after the read strobe.
*/
`timescale 1ns/1ps
module trp_ctrl
   import trp_pkg::*;
(
   trp_if.ctl bus,
   input wire logic [1:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [15:0] sw_rdata
);
   trp_state_t st_q, st_d; // Sequencer state.
   logic [TRP_ADDR_W-1:0] adr_q, adr_d; // Address register.
   logic [TRP_DATA_W-1:0] wd_q, wd_d; // Write data register.
   logic wr_q, wr_d; // Latched direction.
   logic en_q, en_d; // Enable pulse register.
   logic done_q, done_d; // Sticky completion flag.
   logic [TRP_DATA_W-1:0] rd_q, rd_d; // Captured read data.
   logic [15:0] srd_q, srd_d; // Software read data.
   logic go; // Software start request.

   assign go = sw_write && (sw_addr == TRP_REG_CTRL) && sw_wdata[TRP_CTRL_GO];

   // Next-state logic: sequencer plus software registers.
   always_comb begin
      st_d = st_q;
      adr_d = adr_q;
      wd_d = wd_q;
      wr_d = wr_q;
      en_d = 1'b0;
      done_d = done_q;
      rd_d = rd_q;
      srd_d = 16'h0000;
      if (sw_write && sw_addr == TRP_REG_ADDR) begin
         adr_d = sw_wdata[TRP_ADDR_W-1:0];
      end
      if (sw_write && sw_addr == TRP_REG_WDATA) begin
         wd_d = sw_wdata;
      end
      // Reading status clears done; a completion in the same cycle wins below.
      if (sw_read && sw_addr == TRP_REG_STAT) begin
         done_d = 1'b0;
      end
      case (st_q)
         TRP_IDLE: begin
            // A start while busy with an access is ignored.
            if (go) begin
               wr_d = sw_wdata[TRP_CTRL_WR];
               st_d = TRP_WAIT_BUSY;
            end
         end
         TRP_WAIT_BUSY: begin
            if (!bus.reconfig_busy) begin
               en_d = 1'b1; // [R9] [R10]
               st_d = TRP_WAIT_RDY;
            end
         end
         TRP_WAIT_RDY: begin
            // No new enable until ready closes this access.
            if (bus.reconfig_ready) begin
               done_d = 1'b1; // [R11] [R8]
               if (!wr_q) begin
                  rd_d = bus.reconfig_read_data;
               end
               st_d = TRP_IDLE;
            end
         end
         default: st_d = TRP_IDLE;
      endcase
      if (sw_read) begin
         case (sw_addr)
            TRP_REG_CTRL: srd_d = {14'h0, wr_q, 1'b0};
            TRP_REG_ADDR: srd_d = {7'h00, adr_q};
            TRP_REG_WDATA: srd_d = rd_q;
            TRP_REG_STAT: srd_d = {13'h0, bus.reconfig_busy, done_q, st_q != TRP_IDLE};
            default: srd_d = 16'h0000;
         endcase
      end
   end

   // Registers of the controller.
   always_ff @(posedge bus.clk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         st_q <= TRP_IDLE;
         adr_q <= '0;
         wd_q <= '0;
         wr_q <= 1'b0;
         en_q <= 1'b0;
         done_q <= 1'b0;
         rd_q <= '0;
         srd_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         adr_q <= adr_d;
         wd_q <= wd_d;
         wr_q <= wr_d;
         en_q <= en_d;
         done_q <= done_d;
         rd_q <= rd_d;
         srd_q <= srd_d;
      end
   end

   assign bus.reconfig_access_enable_sig = en_q; // [R6] [R10]
   assign bus.reconfig_write_enable = wr_q; // [R7]
   assign bus.reconfig_address = adr_q; // [R3]
   assign bus.reconfig_write_data = wd_q; // [R4]
   assign sw_rdata = srd_q;
endmodule // trp_ctrl

// File: logic/trp_pkg.sv
/*
 Package for the transceiver reconfiguration port: widths, reset values and timing counts shared by
 the interface and both ends. It assumes both ends run on one reconfiguration clock.
*/
// Notes on behaviour
// [R1] Port set absent: outputs held at defaults.
// [R2] Reconfiguration access exists only when selected.
// [R3] Address is nine bits, selects location.
// [R4] Write data is separate sixteen-bit input.
// [R5] Read data returns on sixteen-bit output.
// [R6] Enable low: nothing; high: one access.
// [R7] Write-enable low reads, high writes.
// [R8] Ready pulses: write done or read valid.
// [R9] Busy flag; check clear before posting.
// [R10] All signals on clock edges; enable one cycle.
// [R11] One access outstanding until ready seen.
package trp_pkg;
   // Address and data widths of the reconfiguration space.
   localparam int TRP_ADDR_W = 9;
   localparam int TRP_DATA_W = 16;
   // Default values driven when the port set is not selected.
   localparam logic [15:0] TRP_RDATA_RST = 16'h0000;
   // Access latency of the device end, in reconfiguration clock cycles.
   localparam int TRP_LAT_CYC = 3;
   // Width of the latency counter.
   localparam int TRP_CNT_W = 4;
   // Depth of the device end's configuration space.
   localparam int TRP_DEPTH = 512;
   // Controller register offsets on its software port.
   localparam logic [1:0] TRP_REG_CTRL = 2'h0;
   localparam logic [1:0] TRP_REG_ADDR = 2'h1;
   localparam logic [1:0] TRP_REG_WDATA = 2'h2;
   localparam logic [1:0] TRP_REG_STAT = 2'h3;
   // Field positions in the control register.
   localparam int TRP_CTRL_GO = 0;
   localparam int TRP_CTRL_WR = 1;
   // Field positions in the status register.
   localparam int TRP_STAT_PEND = 0;
   localparam int TRP_STAT_DONE = 1;
   localparam int TRP_STAT_BUSY = 2;
   // Controller state enumeration.
   typedef enum logic [1:0] {TRP_IDLE, TRP_WAIT_BUSY, TRP_WAIT_RDY} trp_state_t;
endpackage

// File: logic/trp_if.sv
/*
 Interface joining the device end of the reconfiguration port to the user-side controller.
 It assumes one clock and one reset shared by both ends.
*/
`timescale 1ns/1ps
interface trp_if
   import trp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n
);
   logic [TRP_ADDR_W-1:0] reconfig_address; // Location being accessed.
   logic [TRP_DATA_W-1:0] reconfig_write_data; // Data to write.
   logic [TRP_DATA_W-1:0] reconfig_read_data; // Data read back.
   logic reconfig_access_enable_sig; // One-cycle access request.
   logic reconfig_write_enable; // High for write.
   logic reconfig_ready; // One-cycle completion.
   logic reconfig_busy; // Device cannot take a request.
   // Device end sees requests and drives answers.
   modport dev (
      input clk, rst_n, reconfig_address, reconfig_write_data, reconfig_access_enable_sig,
      reconfig_write_enable,
      output reconfig_read_data, reconfig_ready, reconfig_busy
   );
   // Controller end drives requests.
   modport ctl (
      input clk, rst_n, reconfig_read_data, reconfig_ready, reconfig_busy,
      output reconfig_address, reconfig_write_data, reconfig_access_enable_sig, reconfig_write_enable
   );
endinterface

// File: logic/trp_device.sv
/*
 Device end of the reconfiguration port: a configuration space with a fixed access latency.
 It assumes the controller keeps one access outstanding and pulses enable for one cycle.
*/
`timescale 1ns/1ps
module trp_device
   import trp_pkg::*;
#(
   parameter bit ENABLED = 1'b1,
   parameter int LAT = TRP_LAT_CYC
)(
   trp_if.dev bus,
   output logic [TRP_ADDR_W-1:0] last_address
);
   // Configuration storage.
   logic [TRP_DATA_W-1:0] mem_q [TRP_DEPTH];
   logic [TRP_CNT_W-1:0] cnt_q, cnt_d; // Cycles left of the access in flight.
   logic act_q, act_d; // An access is in flight.
   logic wr_q, wr_d; // Access in flight is a write.
   logic [TRP_ADDR_W-1:0] adr_q, adr_d; // Latched address.
   logic [TRP_DATA_W-1:0] wd_q, wd_d; // Latched write data.
   logic [TRP_DATA_W-1:0] rd_q, rd_d; // Read data register.
   logic rdy_q, rdy_d; // Ready pulse register.
   logic take; // A request is accepted this cycle.
   logic fin; // The access finishes this cycle.

   // A request is taken only when the port exists and nothing is in flight.
   assign take = ENABLED && bus.reconfig_access_enable_sig && !act_q; // [R2] [R6] [R10]
   assign fin = act_q && (cnt_q == '0);

   // Next-state logic of the access sequencer.
   always_comb begin
      act_d = act_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      adr_d = adr_q;
      wd_d = wd_q;
      rd_d = rd_q;
      rdy_d = 1'b0;
      if (take) begin
         // Latch so the controller may change its outputs right away.
         act_d = 1'b1;
         cnt_d = TRP_CNT_W'(LAT - 1);
         wr_d = bus.reconfig_write_enable; // [R7]
         adr_d = bus.reconfig_address; // [R3]
         wd_d = bus.reconfig_write_data; // [R4]
      end else if (fin) begin
         act_d = 1'b0;
         rdy_d = 1'b1; // [R8]
         if (!wr_q) begin
            rd_d = mem_q[adr_q]; // [R5]
         end
      end else if (act_q) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Registers of the sequencer.
   always_ff @(posedge bus.clk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         act_q <= 1'b0;
         cnt_q <= '0;
         wr_q <= 1'b0;
         adr_q <= '0;
         wd_q <= '0;
         rd_q <= TRP_RDATA_RST;
         rdy_q <= 1'b0;
      end else begin
         act_q <= act_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         adr_q <= adr_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         rdy_q <= rdy_d;
      end
   end

   // Storage has no reset, so it is written in its own clocked process.
   always_ff @(posedge bus.clk) begin
      if (fin && wr_q) begin
         mem_q[adr_q] <= wd_q;
      end
   end

   // Without the port set every output stays at its default.
   assign bus.reconfig_read_data = ENABLED ? rd_q : TRP_RDATA_RST; // [R1]
   assign bus.reconfig_ready = ENABLED ? rdy_q : 1'b0; // [R1]
   assign bus.reconfig_busy = ENABLED ? act_q : 1'b0; // [R9]
   assign last_address = adr_q;
endmodule // trp_device

// File: verif/trp_assertions.sv
/* Checker of the reconfiguration handshake between the two ends.
 Assumes the signals of the interface that joins them, one clock. */
`timescale 1ns/1ps
module trp_assertions
   import trp_pkg::*;
#(parameter int LAT = TRP_LAT_CYC)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [TRP_DATA_W-1:0] reconfig_read_data,
   input wire logic reconfig_access_enable_sig,
   input wire logic reconfig_write_enable,
   input wire logic reconfig_ready,
   input wire logic reconfig_busy
);
   // All checks share the one clock and its reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Ready rises on the edge where the latency counter runs out, so it is sampled one edge later.
   localparam int RDY_DLY = LAT + 1;
   property p_en_pulse; reconfig_access_enable_sig |=> !reconfig_access_enable_sig; endproperty
   a_en_pulse: assert property (p_en_pulse) else $error("enable held too long");
   property p_answer; reconfig_access_enable_sig && !reconfig_busy |-> ##RDY_DLY reconfig_ready; endproperty
   a_answer: assert property (p_answer) else $error("ready late or missing");
   // Busy stands for the three cycles of the default latency and drops as ready rises.
   property p_busy; reconfig_access_enable_sig && !reconfig_busy |=> reconfig_busy [*3] ##1 !reconfig_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy window wrong");
   property p_rdy_pulse; reconfig_ready |=> !reconfig_ready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_rdy_cause; reconfig_ready |-> $past(reconfig_access_enable_sig, RDY_DLY); endproperty
   a_rdy_cause: assert property (p_rdy_cause) else $error("ready without request");
   // The controller keeps one access in flight, so no enable until ready has been sampled.
   property p_gap; reconfig_access_enable_sig |=> !reconfig_access_enable_sig [*4]; endproperty
   a_gap: assert property (p_gap) else $error("second access too early");
   property p_wait_busy; reconfig_busy |-> !reconfig_access_enable_sig; endproperty
   a_wait_busy: assert property (p_wait_busy) else $error("request while busy");
   // Read data only moves when a read completes.
   property p_rd_hold;
      $changed(reconfig_read_data) |-> reconfig_ready && !$past(reconfig_write_enable, RDY_DLY);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   c_read: cover property (reconfig_ready && !$past(reconfig_write_enable, RDY_DLY));
   c_write: cover property (reconfig_ready && $past(reconfig_write_enable, RDY_DLY));
   c_next: cover property (reconfig_ready ##[1:40] reconfig_access_enable_sig);
endmodule // trp_assertions

// File: verif/transceiver_reconfig_port_tb.sv
/* Testbench joining controller and device, plus a device built without the port.
 Assumes the register port of the controller and a 250 MHz clock. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module transceiver_reconfig_port_tb
   import trp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] sw_addr = 2'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_write = 1'b0;
   logic sw_read = 1'b0;
   logic [15:0] sw_rdata;
   logic [8:0] last_address;
   logic seen2 = 1'b0; // Any answer from the absent port.
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   trp_if i_trp_if(.clk(clk), .rst_n(rst_n));
   trp_if i_trp_if2(.clk(clk), .rst_n(rst_n));
   trp_device i_trp_device(.bus(i_trp_if), .last_address(last_address));
   trp_device #(.ENABLED(1'b0)) i_trp_device2(.bus(i_trp_if2), .last_address());
   trp_ctrl i_trp_ctrl(.bus(i_trp_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
      .sw_read(sw_read), .sw_rdata(sw_rdata));
   trp_assertions i_chk(.clk(clk), .rst_n(rst_n), .reconfig_read_data(i_trp_if.reconfig_read_data),
      .reconfig_access_enable_sig(i_trp_if.reconfig_access_enable_sig),
      .reconfig_write_enable(i_trp_if.reconfig_write_enable), .reconfig_ready(i_trp_if.reconfig_ready),
      .reconfig_busy(i_trp_if.reconfig_busy));
   // Prints the verdict; every path out of the run ends here.
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // A hang is cut short long after the last access should end.
   always @(posedge clk) begin
      if (i_trp_if2.reconfig_ready || i_trp_if2.reconfig_busy) begin
         seen2 <= 1'b1;
      end
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_write <= 1'b1;
      @(posedge clk);
      sw_write <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe, so it is sampled there.
   task automatic reg_rd(input logic [1:0] a);
      @(posedge clk);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clk);
      sw_read <= 1'b0;
      #1;
   endtask
   // One full access: load address and data, start, then follow the status bits.
   task automatic acc(input logic wr, input logic [8:0] a, input logic [15:0] d);
      reg_wr(TRP_REG_ADDR, {7'h00, a});
      reg_wr(TRP_REG_WDATA, d);
      reg_wr(TRP_REG_CTRL, {14'h0000, wr, 1'b1});
      reg_rd(TRP_REG_STAT);
      `CHK(sw_rdata[0], 1'b1)
      // Two cycles after the enable the device is in the middle of the access.
      reg_rd(TRP_REG_STAT);
      `CHK(sw_rdata[2:0], 3'b101)
      repeat (8) @(posedge clk);
      reg_rd(TRP_REG_STAT);
      `CHK(sw_rdata[2:0], 3'b010)
      reg_rd(TRP_REG_STAT);
      `CHK(sw_rdata[2:0], 3'b000)
      `CHK(last_address, a)
   endtask
   initial begin
      i_trp_if2.reconfig_address = 9'h000;
      i_trp_if2.reconfig_write_data = 16'h0000;
      i_trp_if2.reconfig_access_enable_sig = 1'b0;
      i_trp_if2.reconfig_write_enable = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b1, 9'h000, 16'ha5c3);
      reg_rd(TRP_REG_CTRL);
      `CHK(sw_rdata, 16'h0002)
      acc(1'b1, 9'h1ff, 16'h5a3c);
      acc(1'b0, 9'h1ff, 16'h0000);
      reg_rd(TRP_REG_WDATA);
      `CHK(sw_rdata, 16'h5a3c)
      reg_rd(TRP_REG_ADDR);
      `CHK(sw_rdata, 16'h01ff)
      reg_rd(TRP_REG_CTRL);
      `CHK(sw_rdata, 16'h0000)
      acc(1'b0, 9'h000, 16'h0000);
      reg_rd(TRP_REG_WDATA);
      `CHK(sw_rdata, 16'ha5c3)
      // A device built without the port must ignore a request.
      @(posedge clk);
      i_trp_if2.reconfig_access_enable_sig <= 1'b1;
      @(posedge clk);
      i_trp_if2.reconfig_access_enable_sig <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(seen2, 1'b0)
      `CHK(i_trp_if2.reconfig_read_data, 16'h0000)
      complete_run();
   end
endmodule // transceiver_reconfig_port_tb
